// ===== fault_event_pkg.sv
// package: offsets, field layouts, reset values and carriers of the fault/converter block
package fault_event_pkg;

  // register offsets on the serial register port
  localparam logic [7:0] FAULT_CONDITION_LIVE_OFS = 8'h10;
  localparam logic [7:0] FAULT_EVENT_LATCH_OFS = 8'h11;
  localparam logic [7:0] FAULT_EVENT_MASK_OFS = 8'h12;
  localparam logic [7:0] PART_IDENTIFICATION_OFS = 8'h13;
  localparam logic [7:0] CONVERTER_CONTROL_OFS = 8'h14;
  localparam logic [7:0] CONVERTER_CHANNEL_DISABLE_OFS = 8'h15;

  // converter control field positions
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_ONE_SHOT_BIT = 6;
  localparam int CTRL_BUS_CURRENT_OFF_BIT = 0;

  // values after reset
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] CHANNEL_OFF_SECONDARY = 8'hf8; // bus v, input v, out v, bat v, bat i
  localparam logic [7:0] CHANNEL_OFF_PRIMARY = 8'h06; // both thermistor channels
  localparam logic [7:0] CHANNEL_OFF_STANDALONE = 8'h00;

  // role of this unit in a paired charger
  typedef enum logic [1:0] {
    ROLE_STANDALONE = 2'h0,
    ROLE_PRIMARY = 2'h1,
    ROLE_SECONDARY = 2'h3
  } unit_role_e;

  // raw comparator levels from the analogue side
  typedef struct packed {
    logic battery_overvoltage;
    logic battery_overcurrent;
    logic bus_overvoltage;
    logic bus_overcurrent;
    logic bus_thermistor_near_overtemp; // within 5% of its threshold
    logic battery_thermistor_near_overtemp; // within 5% of its threshold
    logic battery_thermistor_overtemp;
    logic bus_thermistor_overtemp;
    logic die_overtemp_alarm;
  } fault_sense_s;

  // one register access from the serial front end
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // settings driven into the measurement converter
  typedef struct packed {
    logic enable;
    logic one_shot;
    logic bus_current_channel_off;
    logic [7:0] channel_off; // 7 bus v .. 0 die temp
    logic start; // one-cycle pulse, one-shot request
  } conv_ctrl_s;

endpackage : fault_event_pkg

// ===== fault_event_adc_ctrl.sv
// fault status/flag/mask registers, identification and converter control
//
// Behaviour
// - live fault bits 7..4 follow their conditions
// - bit 3 set when either thermistor near
// - bits 2,1 follow thermistor over-temperature
// - bit 0 follows die over-temperature alarm
// - flags latch events, clear on read
// - unmasked set flag raises interrupt request
// - mask read/write, register reset clears
// - identification read-only, revision and part code
// - converter enable, cleared by all three resets
// - one-shot select, kept through watchdog reset
// - bus-current channel off, kept through watchdog
// - channel-disable register, one bit per channel
// - secondary unit defaults six channels off
// - primary unit defaults thermistor channels off
// - status and flags read-only, reset-proof, zero
// - done drops on request, rises finishing
`timescale 1ns/1ps

module fault_event_adc_ctrl #(
  parameter logic [3:0] DEVICE_REVISION = 4'h5, // arbitrary value
  parameter logic [3:0] PART_CODE = 4'h3 // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire fault_event_pkg::fault_sense_s sense,
  input wire fault_event_pkg::unit_role_e unit_role,
  input wire logic watchdog_triggered_reset,
  input wire logic register_reset,
  input wire fault_event_pkg::reg_req_s req,
  input wire logic conversion_finished,
  output logic [7:0] rdata,
  output logic rvalid,
  output fault_event_pkg::conv_ctrl_s conv,
  output logic conversion_done,
  output logic interrupt_n
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // address match, used by every read and write path
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // channel-disable default for a given role
  function automatic logic [7:0] chan_default(input fault_event_pkg::unit_role_e role);
    chan_default = (role == fault_event_pkg::ROLE_SECONDARY) ?
                   fault_event_pkg::CHANNEL_OFF_SECONDARY :
                   (role == fault_event_pkg::ROLE_PRIMARY) ?
                   fault_event_pkg::CHANNEL_OFF_PRIMARY :
                   fault_event_pkg::CHANNEL_OFF_STANDALONE;
  endfunction : chan_default

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0] live_q; // live fault conditions
  logic [7:0] flag_q; // latched fault events
  logic [7:0] mask_q; // interrupt masks
  logic enable_q; // converter enable
  logic one_shot_q; // 1: one-shot, 0: continuous
  logic ibus_off_q; // bus-current channel off
  logic [7:0] chan_off_q; // per-channel off bits
  logic start_q; // one-shot request pulse
  logic done_q; // conversion-done status
  logic irq_q; // interrupt request, active high
  logic [7:0] rdata_q; // read data holding register
  logic rvalid_q; // read answer strobe
  fault_event_pkg::unit_role_e role_q; // role caught while reset is high

  ////////////////////////////////////////////////////////////////////////////
  // combinational decode

  wire [7:0] live_d; // next live status
  wire [7:0] set_vec; // new events this cycle
  wire [7:0] flag_d; // next flag value
  wire wr_mask; // write to mask
  wire wr_ctrl; // write to converter control
  wire wr_chan; // write to channel disable
  wire rd_flag; // read of the flag register clears it
  wire soft_clear; // register reset request
  wire [7:0] ctrl_view; // converter control as read back
  wire [7:0] id_view; // identification byte
  wire [7:0] rd_mux; // selected read data
  wire start_d; // one-shot request in this write
  wire [7:0] mask_d; // next mask value, shared with the interrupt path
  wire to_continuous; // this edge leaves one-shot mode

  // live bits are registered copies of the comparators, bit 3 the OR of both near alarms
  assign live_d = {sense.battery_overvoltage, sense.battery_overcurrent,
                   sense.bus_overvoltage, sense.bus_overcurrent,
                   sense.bus_thermistor_near_overtemp |
                   sense.battery_thermistor_near_overtemp,
                   sense.battery_thermistor_overtemp,
                   sense.bus_thermistor_overtemp,
                   sense.die_overtemp_alarm};

  // an event is a condition that was absent and is now present
  assign set_vec = live_d & ~live_q;

  // set wins over the read clear, so a same-cycle event is never lost
  assign rd_flag = req.rd & hit(req.addr, fault_event_pkg::FAULT_EVENT_LATCH_OFS);
  assign flag_d = (flag_q & ~{8{rd_flag}}) | set_vec;

  // writes only decode for the three writable registers
  assign wr_mask = req.wr & hit(req.addr, fault_event_pkg::FAULT_EVENT_MASK_OFS);
  assign wr_ctrl = req.wr & hit(req.addr, fault_event_pkg::CONVERTER_CONTROL_OFS);
  assign wr_chan = req.wr & hit(req.addr, fault_event_pkg::CONVERTER_CHANNEL_DISABLE_OFS);
  assign soft_clear = register_reset;

  // the interrupt must see the same mask the register will hold, or a
  // register reset would leave the request one cycle behind the flags
  assign mask_d = soft_clear ? fault_event_pkg::ZERO_BYTE :
                  wr_mask ? req.wdata : mask_q;

  // done must already read 0 on the edge that makes the mode continuous
  assign to_continuous = soft_clear |
                         (wr_ctrl & ~req.wdata[fault_event_pkg::CTRL_ONE_SHOT_BIT]);

  // a one-shot request is an enabling write in one-shot mode
  assign start_d = wr_ctrl & req.wdata[fault_event_pkg::CTRL_ENABLE_BIT] &
                   req.wdata[fault_event_pkg::CTRL_ONE_SHOT_BIT];

  // reserved bits 5:1 read back as zero
  assign ctrl_view = {enable_q, one_shot_q, 5'h0_0, ibus_off_q};
  assign id_view = {DEVICE_REVISION, PART_CODE};

  // read mux; unmapped offsets read as zero
  assign rd_mux =
    hit(req.addr, fault_event_pkg::FAULT_CONDITION_LIVE_OFS) ? live_q :
    hit(req.addr, fault_event_pkg::FAULT_EVENT_LATCH_OFS) ? flag_q :
    hit(req.addr, fault_event_pkg::FAULT_EVENT_MASK_OFS) ? mask_q :
    hit(req.addr, fault_event_pkg::PART_IDENTIFICATION_OFS) ? id_view :
    hit(req.addr, fault_event_pkg::CONVERTER_CONTROL_OFS) ? ctrl_view :
    hit(req.addr, fault_event_pkg::CONVERTER_CHANNEL_DISABLE_OFS) ? chan_off_q :
    fault_event_pkg::ZERO_BYTE;

  ////////////////////////////////////////////////////////////////////////////
  // status and flags: only power reset touches them

  // watchdog and register resets deliberately do not reach here
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      live_q <= fault_event_pkg::ZERO_BYTE;
      flag_q <= fault_event_pkg::ZERO_BYTE;
    end else begin
      live_q <= live_d;
      flag_q <= flag_d;
    end
  end

  // role strap caught while reset is held, used for later register resets
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      role_q <= unit_role;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mask register

  // watchdog reset leaves masks alone
  always_ff @(posedge sys_clk) begin
    if (reset || soft_clear) begin
      mask_q <= fault_event_pkg::ZERO_BYTE;
    end else if (wr_mask) begin
      mask_q <= req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // converter control

  // enable is cleared by every reset; the rest survive the watchdog
  always_ff @(posedge sys_clk) begin
    if (reset || soft_clear || watchdog_triggered_reset) begin
      enable_q <= 1'b0;
    end else if (wr_ctrl) begin
      enable_q <= req.wdata[fault_event_pkg::CTRL_ENABLE_BIT];
    end
  end

  // power reset uses the live strap, register reset the caught one
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      one_shot_q <= 1'b0;
      ibus_off_q <= (unit_role == fault_event_pkg::ROLE_SECONDARY);
      chan_off_q <= chan_default(unit_role);
    end else if (soft_clear) begin
      one_shot_q <= 1'b0;
      ibus_off_q <= (role_q == fault_event_pkg::ROLE_SECONDARY);
      chan_off_q <= chan_default(role_q);
    end else begin
      if (wr_ctrl) begin
        one_shot_q <= req.wdata[fault_event_pkg::CTRL_ONE_SHOT_BIT];
        ibus_off_q <= req.wdata[fault_event_pkg::CTRL_BUS_CURRENT_OFF_BIT];
      end
      if (wr_chan) begin
        chan_off_q <= req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-shot conversion tracking

  // done is a status bit, so only power reset clears it outright
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      start_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      start_q <= start_d;
      if (start_d) begin
        done_q <= 1'b0;
      end else if (!one_shot_q || to_continuous) begin
        done_q <= 1'b0;
      end else if (conversion_finished && enable_q) begin
        done_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt and read answer

  // request follows the next flag and mask state, so it stays up until a read clears or a mask write hides the flags
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_q <= 1'b0;
      rdata_q <= fault_event_pkg::ZERO_BYTE;
      rvalid_q <= 1'b0;
    end else begin
      irq_q <= |(flag_d & ~mask_d);
      rvalid_q <= req.rd;
      if (req.rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // outputs
  assign rdata = rdata_q;
  assign rvalid = rvalid_q;
  assign interrupt_n = ~irq_q;
  assign conversion_done = done_q;
  assign conv.enable = enable_q;
  assign conv.one_shot = one_shot_q;
  assign conv.bus_current_channel_off = ibus_off_q;
  assign conv.channel_off = chan_off_q;
  assign conv.start = start_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // a flag read in a cycle that brings no new event; the answer follows one cycle later
  sequence flag_read_s;
    req.rd && hit(req.addr, fault_event_pkg::FAULT_EVENT_LATCH_OFS) && !(|set_vec);
  endsequence

  live_follow_a: assert property (##1 live_q == $past(live_d))
    else $error("live status does not follow conditions");

  near_alarm_a: assert property (
    (sense.bus_thermistor_near_overtemp || sense.battery_thermistor_near_overtemp)
    |=> live_q[3])
    else $error("thermistor near alarm not shown");

  flag_latch_a: assert property ($rose(live_q[7]) |-> flag_q[7])
    else $error("event not latched into flag");

  flag_clear_a: assert property (flag_read_s |=> flag_q == 8'h00 ##0 rdata == $past(flag_q))
    else $error("flag read did not return and clear");

  irq_mask_a: assert property (
    (|(flag_q & ~mask_q)) |-> interrupt_n == 1'b0)
    else $error("unmasked flag without interrupt");

  irq_hold_a: assert property (
    (!interrupt_n && !req.rd && !req.wr) |=> !interrupt_n)
    else $error("interrupt dropped without read");

  mask_soft_a: assert property (register_reset |=> mask_q == 8'h00)
    else $error("register reset left a mask bit");

  mask_wdt_a: assert property (
    (watchdog_triggered_reset && !register_reset && !wr_mask) |=> $stable(mask_q))
    else $error("watchdog reset changed masks");

  enable_wdt_a: assert property (watchdog_triggered_reset |=> !conv.enable)
    else $error("converter enable survived watchdog");

  mode_keep_a: assert property (
    (watchdog_triggered_reset && !register_reset && !wr_ctrl) |=> $stable(one_shot_q))
    else $error("one-shot select lost on watchdog");

  id_read_a: assert property (
    req.rd && hit(req.addr, fault_event_pkg::PART_IDENTIFICATION_OFS)
    |=> rdata == {DEVICE_REVISION, PART_CODE})
    else $error("identification read wrong");

  ctrl_reserved_a: assert property (
    req.rd && hit(req.addr, fault_event_pkg::CONVERTER_CONTROL_OFS)
    |=> rdata[5:1] == 5'h0_0)
    else $error("reserved control bits not zero");

  secondary_default_a: assert property (
    (register_reset && role_q == fault_event_pkg::ROLE_SECONDARY)
    |=> chan_off_q == 8'hf8 && ibus_off_q)
    else $error("secondary channel defaults wrong");

  primary_default_a: assert property (
    (register_reset && role_q == fault_event_pkg::ROLE_PRIMARY)
    |=> chan_off_q == 8'h06 && !ibus_off_q)
    else $error("primary channel defaults wrong");

  done_drop_a: assert property (start_d |=> !conversion_done ##0 conv.start)
    else $error("done did not drop on request");

  done_cont_a: assert property (!one_shot_q |=> !conversion_done)
    else $error("done set in continuous mode");

  done_leave_a: assert property (to_continuous |=> !conversion_done)
    else $error("done still set after leaving one-shot");

  enable_soft_a: assert property (register_reset |=> !conv.enable)
    else $error("converter enable survived register reset");

endmodule : fault_event_adc_ctrl

// ===== host_model.sv
// host-side model: drives the byte register port one strobe at a time
`timescale 1ns/1ps

module host_model (
  input wire logic sys_clk,
  output var fault_event_pkg::reg_req_s req
);
  // idle port at time zero
  initial req = '0;

  // strobe for one edge, then show the inverse so stale fields never look valid
  task automatic access(input logic rd, input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    req <= {rd, ~rd, addr, data};
    @(posedge sys_clk);
    req <= {2'b00, ~addr, ~data};
  endtask : access
endmodule : host_model

// ===== testbench.sv
// self-checking bench: defaults per role, fault capture, masking, resets, one-shot
`timescale 1ns/1ps

module testbench;
  localparam logic [3:0] REV = 4'h2; // arbitrary value
  localparam logic [3:0] PART = 4'h9; // arbitrary value
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  fault_event_pkg::fault_sense_s sense = '0;
  fault_event_pkg::unit_role_e unit_role = fault_event_pkg::ROLE_STANDALONE;
  logic watchdog_triggered_reset = 1'b0;
  logic register_reset = 1'b0;
  logic conversion_finished = 1'b0;
  fault_event_pkg::reg_req_s req;
  logic [7:0] rdata;
  logic rvalid;
  fault_event_pkg::conv_ctrl_s conv;
  logic conversion_done;
  logic interrupt_n;
  logic [7:0] expq[$]; // expected read data, oldest first
  logic [7:0] dflt[3] = '{8'h00, 8'h06, 8'hf8};
  logic [7:0] ro[4] = '{8'h10, 8'h11, 8'h13, 8'h40};
  logic [7:0] m;
  int miscompares = 0;
  int tests_run = 0;
  int k;
  int b;

  always #2.5 sys_clk = ~sys_clk;

  host_model i_host_model (.sys_clk(sys_clk), .req(req));

  fault_event_adc_ctrl #(.DEVICE_REVISION(REV), .PART_CODE(PART)) i_fault_event_adc_ctrl (
    .sys_clk(sys_clk), .reset(reset), .sense(sense), .unit_role(unit_role),
    .watchdog_triggered_reset(watchdog_triggered_reset), .register_reset(register_reset),
    .req(req), .conversion_finished(conversion_finished), .rdata(rdata), .rvalid(rvalid),
    .conv(conv), .conversion_done(conversion_done), .interrupt_n(interrupt_n)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // note the expectation first, the monitor pops it when rvalid shows
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    i_host_model.access(1'b1, a, 8'h00);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host_model.access(1'b0, a, d);
  endtask : wr

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  task automatic tally_and_finish();
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // read monitor: an answer with no note pending compares against unknown
  always @(posedge sys_clk) begin
    if (rvalid === 1'b1) begin
      chk("read data", (expq.size() > 0) ? expq.pop_front() : 8'hxx, rdata);
    end
  end

  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    #20000;
    miscompares++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h1c8aa23f));
    // power reset under each role strap, secondary last
    for (k = 0; k < 3; k++) begin
      @(posedge sys_clk);
      reset <= 1'b1;
      unit_role <= fault_event_pkg::unit_role_e'((k == 2) ? 3 : k);
      tick(5);
      reset <= 1'b0;
      rd(8'h15, dflt[k]);
      rd(8'h14, {7'h00, k == 2});
      rd(8'h12, 8'h00);
      rd(8'h10, 8'h00);
      rd(8'h11, 8'h00);
      rd(8'h13, {REV, PART});
      chk("channel off", dflt[k], conv.channel_off);
    end
    // each condition alone: live bit, latched flag, request, clear on read
    for (k = 0; k < 9; k++) begin
      b = (k > 3) ? k - 1 : k;
      @(posedge sys_clk);
      sense <= 9'h001 << k;
      tick(2);
      #1 chk("interrupt", 8'h00, {7'h00, interrupt_n});
      rd(8'h10, 8'h01 << b);
      rd(8'h11, 8'h01 << b);
      #1 chk("interrupt", 8'h01, {7'h00, interrupt_n});
      rd(8'h11, 8'h00);
      @(posedge sys_clk);
      sense <= '0;
      tick(2);
      rd(8'h10, 8'h00);
    end
    // masking, then unmasking a pending flag
    m = 8'($urandom());
    wr(8'h12, m);
    rd(8'h12, m);
    wr(8'h12, 8'hff);
    @(posedge sys_clk);
    sense <= 9'h1ff;
    tick(2);
    #1 chk("interrupt", 8'h01, {7'h00, interrupt_n});
    wr(8'h12, 8'hfe);
    tick(1);
    #1 chk("interrupt", 8'h00, {7'h00, interrupt_n});
    rd(8'h11, 8'hff);
    #1 chk("interrupt", 8'h01, {7'h00, interrupt_n});
    @(posedge sys_clk);
    sense <= '0;
    // read-only, unmapped and reserved places ignore writes
    for (k = 0; k < 4; k++) begin
      wr(ro[k], 8'h5a);
      rd(ro[k], (k == 2) ? {REV, PART} : 8'h00);
    end
    wr(8'h14, 8'hbe);
    rd(8'h14, 8'h80);
    // watchdog keeps all but enable, register reset reloads; flags survive both
    wr(8'h14, 8'hc1);
    wr(8'h15, m);
    wr(8'h12, 8'h3c);
    chk("channel off", m, conv.channel_off);
    @(posedge sys_clk);
    sense <= 9'h001;
    @(posedge sys_clk);
    watchdog_triggered_reset <= 1'b1;
    @(posedge sys_clk);
    watchdog_triggered_reset <= 1'b0;
    rd(8'h14, 8'h41);
    rd(8'h12, 8'h3c);
    rd(8'h15, m);
    @(posedge sys_clk);
    register_reset <= 1'b1;
    @(posedge sys_clk);
    register_reset <= 1'b0;
    rd(8'h14, 8'h01);
    rd(8'h12, 8'h00);
    rd(8'h15, 8'hf8);
    rd(8'h10, 8'h01);
    rd(8'h11, 8'h01);
    @(posedge sys_clk);
    sense <= '0;
    // two one-shot rounds so done is seen to drop, then continuous
    for (k = 0; k < 3; k++) begin
      wr(8'h14, (k == 2) ? 8'h80 : 8'hc0);
      #1 chk("start", {7'h00, k < 2}, {7'h00, conv.start});
      chk("done", 8'h00, {7'h00, conversion_done});
      @(posedge sys_clk);
      conversion_finished <= 1'b1;
      @(posedge sys_clk);
      conversion_finished <= 1'b0;
      tick(1);
      #1 chk("done", {7'h00, k < 2}, {7'h00, conversion_done});
    end
    chk("control", 8'h04, {5'h00, conv.enable, conv.one_shot, conv.bus_current_channel_off});
    tick(3);
    chk("reads pending", 8'h00, 8'(expq.size()));
    tally_and_finish();
  end
endmodule : testbench
